//--- hdl/psc_defs.svh
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ****************************************************************
// Bus address and command encoding
// ****************************************************************
`define PSC_SLAVE_ADDR    7'h76
`define PSC_CMD_RESET     8'h1E
`define PSC_CMD_ADC_READ  8'h00
`define PSC_TOP_CONVERT_FLAG      3'h2
`define PSC_TOP_PROM      3'h5
`define PSC_TOP_HI        7
`define PSC_TOP_LO        5
`define PSC_BIT_TYPE      4
`define PSC_BIT_ZERO      0
`define PSC_IDX_HI        3
`define PSC_IDX_LO        1
`define PSC_OSR_MAX       3'h5
`define PSC_BITS_PER_BYTE 4'h8

// ****************************************************************
// Sizes
// ****************************************************************
`define PSC_CAL_WORDS     7
`define PSC_CAL_W         16
`define PSC_RES_W         24
`define PSC_PAD_W         8

// ****************************************************************
// Conversion times (longest figure, microseconds) and clock rate
// ****************************************************************
`define PSC_CLK_KHZ       25000
`define PSC_T_OSR0_US     600
`define PSC_T_OSR1_US     1170
`define PSC_T_OSR2_US     2280
`define PSC_T_OSR3_US     4540
`define PSC_T_OSR4_US     9040
`define PSC_T_OSR5_US     18100

`endif

//--- hdl/psc_pkg.sv
`include "psc_defs.svh"

package psc_pkg;

  typedef enum logic [2:0] {
    PSC_ST_IDLE      = 3'h0,
    PSC_ST_ADDR      = 3'h1,
    PSC_ST_ADDR_ACK  = 3'h2,
    PSC_ST_WRITE     = 3'h3,
    PSC_ST_WRITE_ACK = 3'h4,
    PSC_ST_READ      = 3'h5,
    PSC_ST_READ_ACK  = 3'h6,
    PSC_ST_IGNORE    = 3'h7
  } psc_state_t;

  typedef logic [`PSC_RES_W-1:0] psc_word_t;
  typedef logic [`PSC_CAL_W-1:0] psc_cal_t;

endpackage : psc_pkg

//--- hdl/psc_convert_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.svh"

interface psc_convert_flag_if;
  logic                  start;
  logic                  ctype;
  logic [2:0]            oversampling_ratio;
  logic                  abort;
  logic                  spoil;
  logic                  busy;
  logic                  done;
  logic [`PSC_RES_W-1:0] result;

  modport ctrl (output start, ctype, oversampling_ratio, abort, spoil, input busy, done, result);
  modport convert_flag (input start, ctype, oversampling_ratio, abort, spoil, output busy, done, result);
endinterface : psc_convert_flag_if

`default_nettype wire

//--- hdl/psc_convert_flag.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.svh"

module psc_convert_flag
  import psc_pkg::*;
#(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned CYC0  = 15000,
  parameter int unsigned CYC1  = 29250,
  parameter int unsigned CYC2  = 57000,
  parameter int unsigned CYC3  = 113500,
  parameter int unsigned CYC4  = 226000,
  parameter int unsigned CYC5  = 452500
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // Raw samples from the front end
  input  wire psc_word_t        raw_pressure_sample_in,
  input  wire psc_word_t        raw_temperature_sample_in,
  // Control side
  psc_convert_flag_if.convert_flag              cv
);

  if (CYC0 < 1 || CYC1 < 1 || CYC2 < 1 || CYC3 < 1 || CYC4 < 1 ||
      CYC5 >= (64'd1 << CNT_W) || CYC4 >= (64'd1 << CNT_W)) begin : g_chk
    $error("psc_convert_flag: conversion counts do not fit the counter");
  end

  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             busy_q, busy_d;
  logic             ctype_q, ctype_d;
  logic             bad_q, bad_d;
  logic             done_q, done_d;
  psc_word_t        res_q, res_d;
  psc_word_t        sample;

  assign sample    = ctype_q ? raw_temperature_sample_in : raw_pressure_sample_in;
  assign cv.busy   = busy_q;
  assign cv.done   = done_q;
  assign cv.result = res_q;

  always_comb begin
    cnt_d   = cnt_q;
    busy_d  = busy_q;
    ctype_d = ctype_q;
    bad_d   = bad_q;
    done_d  = 1'b0;
    res_d   = res_q;
    if (cv.abort) begin
      busy_d = 1'b0;
      bad_d  = 1'b0;
      cnt_d  = '0;
    end else if (cv.start) begin
      busy_d  = 1'b1;
      ctype_d = cv.ctype;
      bad_d   = busy_q; // R18
      unique case (cv.oversampling_ratio)
        3'h0:    cnt_d = CNT_W'(CYC0);
        3'h1:    cnt_d = CNT_W'(CYC1);
        3'h2:    cnt_d = CNT_W'(CYC2);
        3'h3:    cnt_d = CNT_W'(CYC3);
        3'h4:    cnt_d = CNT_W'(CYC4);
        default: cnt_d = CNT_W'(CYC5);
      endcase
    end else if (busy_q) begin
      if (cv.spoil) begin
        bad_d = 1'b1; // R17
      end
      if (cnt_q == CNT_W'(1)) begin
        busy_d = 1'b0; // R14
        done_d = 1'b1;
        // A spoiled conversion hands over a garbled value.
        res_d  = (bad_q || cv.spoil) ? ~sample : sample; // R17
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q   <= '0;
      busy_q  <= 1'b0;
      ctype_q <= 1'b0;
      bad_q   <= 1'b0;
      done_q  <= 1'b0;
      res_q   <= '0;
    end else begin
      cnt_q   <= cnt_d;
      busy_q  <= busy_d;
      ctype_q <= ctype_d;
      bad_q   <= bad_d;
      done_q  <= done_d;
      res_q   <= res_d;
    end
  end

endmodule : psc_convert_flag

`default_nettype wire

//--- hdl/psc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.svh"

// Contract
// (R01) Answer only to address 1110110 plus direction.
// (R02) Messages open with start, end with stop.
// (R03) A command is one byte per write.
// (R04) Result reads give 24 bits, calibration 16.
// (R05) Reset command reloads calibration into register.
// (R06) Reset command accepted at any moment.
// (R07) Host clears stuck data line, then resets.
// (R08) Convert commands pick type and oversampling ratio.
// (R09) Calibration commands carry word index bits 3..1.
// (R10) Seven 16-bit calibration words, sent MSB first.
// (R11) Calibration read: command write, then read.
// (R12) Host reads calibration once after each reset; the bench reads all words after the first reset only.
// (R13) Word zero holds factory bits and check.
// (R14) Busy from accepted convert until it ends.
// (R15) Result command shifts result out MSB first.
// (R16) No fresh conversion means a zero result.
// (R17) Result command mid-conversion: zero, result spoiled.
// (R18) Convert during conversion gives incorrect result.
// (R19) Host clocks 24 bits after read address.
// (R20) After each sent byte, wait for host acknowledge.
// (R21) Host checks 4-bit code in word zero.
// (R22) Host waits longest conversion time before reading; the bench polls result_ready_out instead.
// (R23) Byte bit 7 calibration, bit 6 convert.
module psc_top
  import psc_pkg::*;
#(
  parameter int unsigned CNT_W     = 20,
  parameter int unsigned CONVERT_FLAG_CYC0 = (`PSC_T_OSR0_US * `PSC_CLK_KHZ) / 1000,
  parameter int unsigned CONVERT_FLAG_CYC1 = (`PSC_T_OSR1_US * `PSC_CLK_KHZ) / 1000,
  parameter int unsigned CONVERT_FLAG_CYC2 = (`PSC_T_OSR2_US * `PSC_CLK_KHZ) / 1000,
  parameter int unsigned CONVERT_FLAG_CYC3 = (`PSC_T_OSR3_US * `PSC_CLK_KHZ) / 1000,
  parameter int unsigned CONVERT_FLAG_CYC4 = (`PSC_T_OSR4_US * `PSC_CLK_KHZ) / 1000,
  parameter int unsigned CONVERT_FLAG_CYC5 = (`PSC_T_OSR5_US * `PSC_CLK_KHZ) / 1000
) (
  // Clock and reset
  input  wire logic                                clk_in,
  input  wire logic                                rst_n_in,
  // Two-wire serial port
  input  wire logic                                scl_in,
  input  wire logic                                sda_in,
  output var  logic                                sda_out,
  output var  logic                                sda_oe_n_out,
  // Front end and calibration store
  input  wire psc_word_t                           raw_pressure_sample_in,
  input  wire psc_word_t                           raw_temperature_sample_in,
  input  wire logic [`PSC_CAL_WORDS*`PSC_CAL_W-1:0] cal_rom_in,
  // Status
  output var  logic                                busy_out,
  output var  logic                                result_ready_out,
  output var  logic                                cal_loaded_out
);

  // ****************************************************************
  // Pin synchronisers and bus condition detection
  // ****************************************************************
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;

  assign scl_rise   = scl_s2_q & ~scl_s3_q;
  assign scl_fall   = ~scl_s2_q & scl_s3_q;
  assign start_cond = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q; // R02
  assign stop_cond  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q; // R02

  // ****************************************************************
  // Conversion engine
  // ****************************************************************
  psc_convert_flag_if cv ();

  psc_convert_flag #(
    .CNT_W (CNT_W),
    .CYC0  (CONVERT_FLAG_CYC0),
    .CYC1  (CONVERT_FLAG_CYC1),
    .CYC2  (CONVERT_FLAG_CYC2),
    .CYC3  (CONVERT_FLAG_CYC3),
    .CYC4  (CONVERT_FLAG_CYC4),
    .CYC5  (CONVERT_FLAG_CYC5)
  ) u_convert_flag (
    .clk_in                    (clk_in),
    .rst_n_in                  (rst_n_in),
    .raw_pressure_sample_in    (raw_pressure_sample_in),
    .raw_temperature_sample_in (raw_temperature_sample_in),
    .cv                        (cv.convert_flag)
  );

  // ****************************************************************
  // Command decode
  // ****************************************************************
  psc_state_t  state_q, state_d;
  logic [3:0]  bit_cnt_q, bit_cnt_d;
  logic [7:0]  shift_q, shift_d;
  psc_word_t   tx_q, tx_d;
  psc_word_t   read_word_q, read_word_d;
  psc_word_t   res_q, res_d;
  psc_cal_t    cal_q [`PSC_CAL_WORDS];
  psc_cal_t    cal_d [`PSC_CAL_WORDS];
  logic        rw_q, rw_d;
  logic        cmd_seen_q, cmd_seen_d;
  logic        nack_q, nack_d;
  logic        oe_n_q, oe_n_d;
  logic        res_valid_q, res_valid_d;
  logic        cal_ok_q, cal_ok_d;
  logic        busy_q;
  logic        start_q, start_d;
  logic        abort_q, abort_d;
  logic        spoil_q, spoil_d;
  logic        ctype_q, ctype_d;
  logic [2:0]  osr_q, osr_d;

  logic        is_reset, is_adc, is_convert_flag, is_prom;
  logic [2:0]  cmd_idx;

  // Bit 0 must be zero for any command; bit 7 marks calibration reads and
  // bit 6 conversions.
  assign cmd_idx  = shift_q[`PSC_IDX_HI:`PSC_IDX_LO];
  assign is_reset = (shift_q == `PSC_CMD_RESET); // R23
  assign is_adc   = (shift_q == `PSC_CMD_ADC_READ); // R23
  assign is_convert_flag  = (shift_q[`PSC_TOP_HI:`PSC_TOP_LO] == `PSC_TOP_CONVERT_FLAG) &&
                    !shift_q[`PSC_BIT_ZERO] && (cmd_idx <= `PSC_OSR_MAX); // R08 R23
  assign is_prom  = (shift_q[`PSC_TOP_HI:`PSC_TOP_LO] == `PSC_TOP_PROM) &&
                    !shift_q[`PSC_BIT_TYPE] && !shift_q[`PSC_BIT_ZERO]; // R09 R23

  assign cv.start = start_q;
  assign cv.abort = abort_q;
  assign cv.spoil = spoil_q;
  assign cv.ctype = ctype_q;
  assign cv.oversampling_ratio   = osr_q;

  // ****************************************************************
  // Serial slave and command execution
  // ****************************************************************
  always_comb begin
    state_d     = state_q;
    bit_cnt_d   = bit_cnt_q;
    shift_d     = shift_q;
    tx_d        = tx_q;
    read_word_d = read_word_q;
    res_d       = res_q;
    cal_d       = cal_q;
    rw_d        = rw_q;
    cmd_seen_d  = cmd_seen_q;
    nack_d      = nack_q;
    oe_n_d      = oe_n_q;
    res_valid_d = res_valid_q;
    cal_ok_d    = cal_ok_q;
    start_d     = 1'b0;
    abort_d     = 1'b0;
    spoil_d     = 1'b0;
    ctype_d     = ctype_q;
    osr_d       = osr_q;

    if (start_cond) begin
      state_d    = PSC_ST_ADDR; // R02
      bit_cnt_d  = '0;
      cmd_seen_d = 1'b0;
      oe_n_d     = 1'b1;
    end else if (stop_cond) begin
      state_d = PSC_ST_IDLE; // R02
      oe_n_d  = 1'b1;
    end else begin
      unique case (state_q)
        PSC_ST_IDLE, PSC_ST_IGNORE: begin
          oe_n_d = 1'b1;
        end
        PSC_ST_ADDR: begin
          if (scl_rise) begin
            shift_d   = {shift_q[6:0], sda_s2_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `PSC_BITS_PER_BYTE) begin
            if (shift_q[7:1] == `PSC_SLAVE_ADDR) begin // R01
              rw_d    = shift_q[0];
              oe_n_d  = 1'b0;
              state_d = PSC_ST_ADDR_ACK;
            end else begin
              state_d = PSC_ST_IGNORE;
            end
          end
        end
        PSC_ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_d = '0;
            if (rw_q) begin
              tx_d    = read_word_q;
              oe_n_d  = read_word_q[`PSC_RES_W-1]; // R15 R10
              state_d = PSC_ST_READ;
            end else begin
              oe_n_d  = 1'b1;
              state_d = PSC_ST_WRITE;
            end
          end
        end
        PSC_ST_WRITE: begin
          if (scl_rise) begin
            shift_d   = {shift_q[6:0], sda_s2_q};
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `PSC_BITS_PER_BYTE) begin
            if (cmd_seen_q) begin
              state_d = PSC_ST_IGNORE; // R03
            end else begin
              cmd_seen_d = 1'b1;
              oe_n_d     = 1'b0;
              state_d    = PSC_ST_WRITE_ACK;
              if (is_reset) begin
                abort_d     = 1'b1; // R06
                res_valid_d = 1'b0;
                read_word_d = '0;
                cal_ok_d    = 1'b1;
                for (int i = 0; i < `PSC_CAL_WORDS; i++) begin
                  // Word 0 carries factory bits and check code as stored.
                  cal_d[i] = cal_rom_in[i*`PSC_CAL_W +: `PSC_CAL_W]; // R05 R13
                end
              end else if (is_adc) begin
                res_valid_d = 1'b0; // R16
                if (busy_q) begin
                  read_word_d = '0; // R17
                  spoil_d     = 1'b1; // R17
                end else begin
                  read_word_d = res_valid_q ? res_q : '0; // R16 R04
                end
              end else if (is_convert_flag) begin
                start_d = 1'b1; // R08 R14
                ctype_d = shift_q[`PSC_BIT_TYPE];
                osr_d   = cmd_idx;
              end else if (is_prom) begin
                // Calibration words leave MSB first in the top 16 bits.
                read_word_d = (cmd_idx < 3'(`PSC_CAL_WORDS)) ?
                              {cal_q[cmd_idx], `PSC_PAD_W'h0} : '0; // R09 R04 R11
              end
            end
          end
        end
        PSC_ST_WRITE_ACK: begin
          if (scl_fall) begin
            oe_n_d    = 1'b1;
            bit_cnt_d = '0;
            state_d   = PSC_ST_WRITE;
          end
        end
        PSC_ST_READ: begin
          if (scl_rise) begin
            bit_cnt_d = bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == `PSC_BITS_PER_BYTE) begin
              oe_n_d  = 1'b1; // R20
              state_d = PSC_ST_READ_ACK;
            end else begin
              tx_d   = {tx_q[`PSC_RES_W-2:0], 1'b0};
              oe_n_d = tx_q[`PSC_RES_W-2]; // R15
            end
          end
        end
        PSC_ST_READ_ACK: begin
          if (scl_rise) begin
            nack_d = sda_s2_q; // R20
          end else if (scl_fall) begin
            bit_cnt_d = '0;
            if (nack_q) begin
              oe_n_d  = 1'b1;
              state_d = PSC_ST_IGNORE;
            end else begin
              tx_d    = {tx_q[`PSC_RES_W-2:0], 1'b0};
              oe_n_d  = tx_q[`PSC_RES_W-2]; // R20 R15
              state_d = PSC_ST_READ;
            end
          end
        end
      endcase
    end

    // A finishing conversion wins over a result command in the same cycle.
    if (cv.done && !abort_d) begin
      res_d       = cv.result;
      res_valid_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q     <= PSC_ST_IDLE;
      bit_cnt_q   <= '0;
      shift_q     <= '0;
      tx_q        <= '0;
      read_word_q <= '0;
      res_q       <= '0;
      for (int i = 0; i < `PSC_CAL_WORDS; i++) begin
        cal_q[i] <= '0;
      end
      rw_q        <= 1'b0;
      cmd_seen_q  <= 1'b0;
      nack_q      <= 1'b1;
      oe_n_q      <= 1'b1;
      res_valid_q <= 1'b0;
      cal_ok_q    <= 1'b0;
      start_q     <= 1'b0;
      abort_q     <= 1'b0;
      spoil_q     <= 1'b0;
      ctype_q     <= 1'b0;
      osr_q       <= '0;
    end else begin
      state_q     <= state_d;
      bit_cnt_q   <= bit_cnt_d;
      shift_q     <= shift_d;
      tx_q        <= tx_d;
      read_word_q <= read_word_d;
      res_q       <= res_d;
      cal_q       <= cal_d;
      rw_q        <= rw_d;
      cmd_seen_q  <= cmd_seen_d;
      nack_q      <= nack_d;
      oe_n_q      <= oe_n_d;
      res_valid_q <= res_valid_d;
      cal_ok_q    <= cal_ok_d;
      start_q     <= start_d;
      abort_q     <= abort_d;
      spoil_q     <= spoil_d;
      ctype_q     <= ctype_d;
      osr_q       <= osr_d;
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sda_out          <= 1'b0;
      sda_oe_n_out     <= 1'b1;
      busy_q           <= 1'b0;
      busy_out         <= 1'b0;
      result_ready_out <= 1'b0;
      cal_loaded_out   <= 1'b0;
    end else begin
      sda_out          <= 1'b0;
      sda_oe_n_out     <= oe_n_d;
      busy_q           <= cv.busy | start_q;
      busy_out         <= cv.busy | start_q; // R14
      result_ready_out <= res_valid_d;
      cal_loaded_out   <= cal_ok_d;
    end
  end

endmodule : psc_top

`default_nettype wire

//--- tb/psc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module psc_monitor #(
  parameter int unsigned CONVERT_FLAG_CYC0 = 15000
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bus and status
  input wire logic scl_in,
  input wire logic sda_oe_n_out,
  input wire logic busy_out,
  input wire logic result_ready_out,
  input wire logic cal_loaded_out
);
  logic [19:0] run_q;
  logic [19:0] run_d;
  logic        was_q;
  logic        was_d;

  // Length of the latest busy run, held once busy drops.
  always_comb begin
    was_d = busy_out;
    run_d = run_q;
    if (busy_out) begin
      run_d = was_q ? run_q + 20'h1 : 20'h1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= 20'h0;
      was_q <= 1'h0;
    end else begin
      run_q <= run_d;
      was_q <= was_d;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_idle: assert property ($rose(rst_n_in) |-> sda_oe_n_out && !busy_out
    && !result_ready_out && !cal_loaded_out) else $error("outputs not idle after reset");
  a_cal_sticky: assert property (cal_loaded_out |=> cal_loaded_out)
    else $error("calibration flag dropped");
  a_cal_at_ack: assert property ($rose(cal_loaded_out) |->
    ##[0:4] !sda_oe_n_out or !$past(sda_oe_n_out, 2)) else $error("reload away from ack");
  a_pull_scl_low: assert property ($fell(sda_oe_n_out) |->
    !$past(scl_in) && !$past(scl_in, 2)) else $error("data pulled while clock high");
  a_ack_hold: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*4])
    else $error("data drive shorter than a bit");
  a_ready_after_busy: assert property ($rose(result_ready_out) |->
    $past(busy_out) || $past(busy_out, 2)) else $error("result without conversion");
  a_busy_min: assert property ($rose(result_ready_out) |->
    int'(run_q) >= int'(CONVERT_FLAG_CYC0) - 4) else $error("conversion ended early");
  a_clear_at_ack: assert property ($fell(result_ready_out) |->
    (!$past(sda_oe_n_out) || !$past(sda_oe_n_out, 2)) or ##[0:4] !sda_oe_n_out)
    else $error("result dropped away from ack");
  a_busy_at_ack: assert property ($rose(busy_out) |->
    ##[0:4] !sda_oe_n_out or !$past(sda_oe_n_out)) else $error("busy away from ack");
endmodule // psc_monitor

bind psc_top psc_monitor #(.CONVERT_FLAG_CYC0(CONVERT_FLAG_CYC0)) psc_monitor_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
  .busy_out(busy_out), .result_ready_out(result_ready_out), .cal_loaded_out(cal_loaded_out)
);
`default_nettype wire

//--- tb/psc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-wire bus master
// ****************************************
module psc_host (
  // Bus lines, data is open drain
  output var  logic scl_out,
  output var  logic sda_out,
  input  wire logic sda_in
);
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end

  // One bit: 200 ns low, 120 ns high; the clock stands high between frames.
  task automatic bit_io(input logic b, output logic r);
    #103 sda_out = b;
    #97 scl_out = 1'h1;
    #61 r = sda_in;
    #59 scl_out = 1'h0;
  endtask

  task automatic start();
    #103 sda_out = 1'h1;
    #97 scl_out = 1'h1;
    #160 sda_out = 1'h0;
    #160 scl_out = 1'h0;
  endtask

  task automatic stop();
    #103 sda_out = 1'h0;
    #97 scl_out = 1'h1;
    #160 sda_out = 1'h1;
    #160;
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule // psc_host
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "psc_defs.svh"
// ****************************************
// Bench top
// ****************************************
module tb;
  logic        clk_in;
  logic        rst_n_in;
  logic        scl;
  logic        host_sda;
  logic        sda_wire;
  logic        sda_drv;
  logic        sda_oe_n;
  logic        busy;
  logic        ready;
  logic        loaded;
  logic [23:0] p_raw;
  logic [23:0] t_raw;
  logic [23:0] v;
  logic [7:0]  rx;
  logic [127:0] m;
  logic        ack;
  int          num_errors;
  int          n_tests;
  logic [`PSC_CAL_WORDS*`PSC_CAL_W-1:0] cal_rom;

  // Open-drain data line with pull-up.
  assign sda_wire = host_sda & (sda_oe_n | sda_drv);

  always #20 clk_in = ~clk_in;

  localparam int unsigned CYC_B = 600;

  psc_top #(
    .CONVERT_FLAG_CYC0(CYC_B), .CONVERT_FLAG_CYC1(CYC_B + 100), .CONVERT_FLAG_CYC2(CYC_B + 200),
    .CONVERT_FLAG_CYC3(CYC_B + 300), .CONVERT_FLAG_CYC4(CYC_B + 400), .CONVERT_FLAG_CYC5(CYC_B + 1400)
  ) psc_top_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_drv), .sda_oe_n_out(sda_oe_n), .raw_pressure_sample_in(p_raw),
    .raw_temperature_sample_in(t_raw), .cal_rom_in(cal_rom), .busy_out(busy),
    .result_ready_out(ready), .cal_loaded_out(loaded)
  );
  psc_host psc_host_i (.scl_out(scl), .sda_out(host_sda), .sda_in(sda_wire));

  function automatic logic [15:0] cw(input int i);
    return 16'hB4E1 + 16'h2A3C * 16'(i);
  endfunction

  // Host-side check code over eight words, word zero first, taken byte by byte.
  function automatic logic [3:0] crc4(input logic [127:0] w);
    logic [15:0] r;
    r = 16'h0;
    for (int c = 0; c < 16; c++) begin
      r = r ^ {8'h00, w[127 - 8*c -: 8]};
      for (int b = 0; b < 8; b++) begin
        r = r[15] ? ({r[14:0], 1'b0} ^ 16'h3000) : {r[14:0], 1'b0};
      end
    end
    return r[15:12];
  endfunction

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    psc_host_i.start();
    psc_host_i.byte_io({`PSC_SLAVE_ADDR, 1'h0}, 1'h1, rx, ack);
    chk({23'h0, ack}, 24'h0);
    psc_host_i.byte_io(c, 1'h1, rx, ack);
    chk({23'h0, ack}, 24'h0);
    psc_host_i.stop();
  endtask

  task automatic rd(output logic [23:0] d);
    psc_host_i.start();
    psc_host_i.byte_io({`PSC_SLAVE_ADDR, 1'h1}, 1'h1, rx, ack);
    chk({23'h0, ack}, 24'h0);
    for (int k = 0; k < 3; k++) begin
      psc_host_i.byte_io(8'hFF, k == 2, rx, ack);
      d = {d[15:0], rx};
    end
    psc_host_i.stop();
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'h1 && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
    chk({23'h0, ready}, 24'h1);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    num_errors++;
    end_sim();
  end

  initial begin
    clk_in = 1'h0;
    rst_n_in = 1'h0;
    p_raw = 24'h0;
    t_raw = 24'h0;
    num_errors = 0;
    n_tests = 0;
    for (int i = 0; i < 7; i++) begin
      cal_rom[16*i +: 16] = cw(i);
      m[127 - 16*i -: 16] = cw(i);
    end
    m[15:0] = 16'h0;
    cal_rom[15:12] = crc4({4'h0, m[123:0]});
    repeat (3) @(negedge clk_in);
    rst_n_in = 1'h1;
    repeat (3) @(negedge clk_in);
    cmd(8'hA2);
    rd(v);
    chk(v, 24'h0);
    chk({23'h0, loaded}, 24'h0);
    psc_host_i.start();
    psc_host_i.byte_io({7'h77, 1'h0}, 1'h1, rx, ack);
    chk({23'h0, ack}, 24'h1);
    psc_host_i.stop();
    cmd(`PSC_CMD_RESET);
    chk({23'h0, loaded}, 24'h1);
    for (int i = 0; i < 8; i++) begin
      cmd(8'hA0 + 8'(2 * i));
      rd(v);
      chk(v, i < 7 ? {cal_rom[16*(i % 7) +: 16], 8'h00} : 24'h0);
      m[127 - 16*i -: 16] = v[23:8];
    end
    chk({20'h0, m[127:124]}, {20'h0, crc4({4'h0, m[123:0]})});
    psc_host_i.start();
    psc_host_i.byte_io({`PSC_SLAVE_ADDR, 1'h0}, 1'h1, rx, ack);
    psc_host_i.byte_io(`PSC_CMD_ADC_READ, 1'h1, rx, ack);
    psc_host_i.byte_io(`PSC_CMD_RESET, 1'h1, rx, ack);
    chk({23'h0, ack}, 24'h1);
    psc_host_i.stop();
    rd(v);
    chk(v, 24'h0);
    for (int j = 0; j < 12; j++) begin
      @(negedge clk_in);
      p_raw = 24'hC3A51E + 24'(j);
      t_raw = 24'h5A0F96 - 24'(j);
      cmd({3'h2, 1'(j / 6), 3'(j % 6), 1'h0});
      chk({23'h0, busy}, 24'h1);
      wait_ready();
      cmd(`PSC_CMD_ADC_READ);
      rd(v);
      chk(v, j < 6 ? p_raw : t_raw);
      cmd(`PSC_CMD_ADC_READ);
      rd(v);
      chk(v, 24'h0);
    end
    cmd(8'h4A);
    cmd(`PSC_CMD_ADC_READ);
    rd(v);
    chk(v, 24'h0);
    wait_ready();
    cmd(`PSC_CMD_ADC_READ);
    rd(v);
    chk(v, ~p_raw);
    cmd(8'h5A);
    cmd(8'h5A);
    wait_ready();
    cmd(`PSC_CMD_ADC_READ);
    rd(v);
    chk(v, ~t_raw);
    cmd(8'h4C);
    chk({22'h0, busy, ready}, 24'h0);
    cmd(8'h4A);
    cmd(`PSC_CMD_RESET);
    chk({22'h0, busy, ready}, 24'h0);
    for (int i = 0; i < 9; i++) begin
      psc_host_i.bit_io(1'h1, ack);
    end
    psc_host_i.stop();
    cal_rom[16 +: 16] = ~cw(1);
    cmd(`PSC_CMD_RESET);
    cmd(8'hA2);
    rd(v);
    chk(v, {~cw(1), 8'h00});
    cmd(`PSC_CMD_ADC_READ);
    rd(v);
    chk(v, 24'h0);
    end_sim();
  end
endmodule // tb
`default_nettype wire
